// ### sdwp_pkg.sv
package sdwp_pkg;
  localparam int          WORD_BITS    = 16;
  localparam int          CODE_BITS    = 12;
  localparam int          MODE_BITS    = 2;
  localparam int          CODE_LSB     = 0;
  localparam int          MODE_LSB     = 12;
  localparam logic [4:0]  BIT_COUNT    = 5'h10;
  localparam logic [4:0]  CNT_ZERO     = 5'h00;
  localparam logic [4:0]  CNT_ONE      = 5'h01;
  localparam logic [11:0] ZERO_CODE    = 12'h000;
  localparam logic [1:0]  MODE_NORMAL  = 2'h0;
  localparam logic [15:0] WORD_ZERO    = 16'h0000;
  localparam int          FIFO_DEPTH   = 16;
  localparam int          FIFO_AW      = 4;
  localparam int          SYS_CLK_HZ   = 20000000;
  localparam int          SCLK_MAX_HZ  = 30000000;
  localparam logic [2:0]  SYNC_RESET   = 3'h7;
  localparam logic [2:0]  SCLK_RESET   = 3'h0;
  localparam logic [2:0]  DIN_RESET    = 3'h0;
  typedef enum logic [1:0] {
    SDWP_IDLE  = 2'b00,
    SDWP_SHIFT = 2'b01,
    SDWP_DONE  = 2'b10
  } sdwp_state_t;
endpackage

// ### sdwp_fifo.sv
// the word buffer sits with the port logic, so one design file holds all the logic

// ### sdwp_serial_dac_write_port.sv
`timescale 1ns/1ns
// Operation
// - while frame select is low each of the first sixteen falling serial clock edges shifts the data bit into a 16-bit register.
// - with frame select high no clock edge shifts anything.
// - the sixteenth falling edge after frame select falls loads the word and updates the output.
// - frame select rising before the sixteenth edge aborts the frame and leaves the output unchanged.
// - reset forces the zero code on the output until the first complete frame.
// - each completed frame delivers a 12-bit code that drives the output level.
module sdwp_serial_dac_write_port (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        frameSelN,
  input  wire logic        serialClk,
  input  wire logic        serialData,
  output logic [11:0]      analog_output,
  output logic [1:0]       powerMode,
  output logic             updateStrobe,
  output logic             abortStrobe
);
  ////////////////////////////////////////////////////////////////////////////
  logic [2:0]        syncSh;
  logic [2:0]        sclkSh;
  logic [2:0]        dinSh;
  logic              frameLow;
  logic              frameLowPrev;
  logic              sclkLvl;
  logic              sclkPrev;
  logic              dinLvl;
  logic              sclkFall;
  logic              frameStart;
  logic              frameEnd;
  logic [15:0]       shiftReg;
  logic [4:0]        bitCnt;
  sdwp_pkg::sdwp_state_t state;
  logic              wordValid;
  logic              wordReady;
  logic [15:0]       wordData;
  logic              fifoValid;
  logic [15:0]       fifoData;

  // three stages: only stages two and three are looked at, so metastability is contained
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      syncSh <= sdwp_pkg::SYNC_RESET;
      sclkSh <= sdwp_pkg::SCLK_RESET;
      dinSh  <= sdwp_pkg::DIN_RESET;
    end else begin
      syncSh <= {syncSh[1:0], frameSelN};
      sclkSh <= {sclkSh[1:0], serialClk};
      dinSh  <= {dinSh[1:0], serialData};
    end
  end

  // a level changes only when stages two and three agree
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      frameLow     <= 1'b0;
      frameLowPrev <= 1'b0;
      sclkLvl      <= 1'b0;
      sclkPrev     <= 1'b0;
      dinLvl       <= 1'b0;
    end else begin
      if (syncSh[2] == syncSh[1]) begin
        frameLow <= !syncSh[2];
      end
      if (sclkSh[2] == sclkSh[1]) begin
        sclkLvl <= sclkSh[2];
      end
      if (dinSh[2] == dinSh[1]) begin
        dinLvl <= dinSh[2];
      end
      frameLowPrev <= frameLow;
      sclkPrev     <= sclkLvl;
    end
  end

  // limitation: 20 MHz sampling follows a serial clock of a few MHz only, not the full 30 MHz
  assign sclkFall   = sclkPrev && !sclkLvl;
  assign frameStart = frameLow && !frameLowPrev;
  assign frameEnd   = !frameLow && frameLowPrev;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state       <= sdwp_pkg::SDWP_IDLE;
      bitCnt      <= sdwp_pkg::CNT_ZERO;
      shiftReg    <= sdwp_pkg::WORD_ZERO;
      abortStrobe <= 1'b0;
    end else begin
      abortStrobe <= 1'b0;
      case (state)
        sdwp_pkg::SDWP_IDLE: begin
          if (frameStart) begin
            state  <= sdwp_pkg::SDWP_SHIFT;
            bitCnt <= sdwp_pkg::CNT_ZERO;
          end
        end
        sdwp_pkg::SDWP_SHIFT: begin
          if (frameEnd) begin
            state       <= sdwp_pkg::SDWP_IDLE;
            abortStrobe <= 1'b1;
          end else if (sclkFall) begin
            shiftReg <= {shiftReg[14:0], dinLvl};
            bitCnt   <= bitCnt + sdwp_pkg::CNT_ONE;
            if (bitCnt == sdwp_pkg::BIT_COUNT - sdwp_pkg::CNT_ONE) begin
              state <= sdwp_pkg::SDWP_DONE;
            end
          end
        end
        sdwp_pkg::SDWP_DONE: begin
          // later edges are ignored until frame select goes high again
          if (frameEnd) begin
            state <= sdwp_pkg::SDWP_IDLE;
          end
        end
        default: begin
          state <= sdwp_pkg::SDWP_IDLE;
        end
      endcase
    end
  end

  // one-cycle pulse when the sixteenth bit lands
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wordValid <= 1'b0;
    end else begin
      wordValid <= (state == sdwp_pkg::SDWP_SHIFT) && !frameEnd && sclkFall
                   && (bitCnt == sdwp_pkg::BIT_COUNT - sdwp_pkg::CNT_ONE);
    end
  end
  assign wordData = shiftReg;

  ////////////////////////////////////////////////////////////////////////////
  // the converter side always drains, so the fifo only absorbs one word of latency;
  // a full fifo drops a word, which the shifter cannot stall for anyway
  sdwp_fifo #(
    .WIDTH (sdwp_pkg::WORD_BITS),
    .DEPTH (sdwp_pkg::FIFO_DEPTH),
    .AW    (sdwp_pkg::FIFO_AW)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .inValid  (wordValid),
    .inReady  (wordReady),
    .inData   (wordData),
    .outValid (fifoValid),
    .outReady (1'b1),
    .outData  (fifoData)
  );

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      analog_output <= sdwp_pkg::ZERO_CODE;
      powerMode     <= sdwp_pkg::MODE_NORMAL;
      updateStrobe  <= 1'b0;
    end else begin
      updateStrobe <= fifoValid;
      if (fifoValid) begin
        analog_output <= fifoData[sdwp_pkg::CODE_LSB +: sdwp_pkg::CODE_BITS];
        powerMode     <= fifoData[sdwp_pkg::MODE_LSB +: sdwp_pkg::MODE_BITS];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_lastBit;
    (state == sdwp_pkg::SDWP_SHIFT) && !frameEnd && sclkFall
      && (bitCnt == sdwp_pkg::BIT_COUNT - sdwp_pkg::CNT_ONE);
  endsequence
  sequence s_update;
    ##3 updateStrobe;
  endsequence

  property p_shift;
    @(posedge clk_sys) disable iff (!nrst)
      (state == sdwp_pkg::SDWP_SHIFT) && !frameEnd && sclkFall
      |=> shiftReg[0] == $past(dinLvl);
  endproperty
  a_shift: assert property (p_shift) else $error("bit not shifted");

  property p_noShiftHigh;
    @(posedge clk_sys) disable iff (!nrst)
      !frameLow && !frameLowPrev |=> $stable(shiftReg);
  endproperty
  a_noShiftHigh: assert property (p_noShiftHigh) else $error("shift while idle");

  property p_update;
    @(posedge clk_sys) disable iff (!nrst) s_lastBit |-> s_update;
  endproperty
  a_update: assert property (p_update) else $error("no update after 16th edge");

  property p_abort;
    @(posedge clk_sys) disable iff (!nrst)
      (state == sdwp_pkg::SDWP_SHIFT) && frameEnd |=> abortStrobe ##1 !wordValid;
  endproperty
  a_abort: assert property (p_abort) else $error("abort not flagged");

  property p_holdValue;
    @(posedge clk_sys) disable iff (!nrst)
      !updateStrobe |-> $stable(analog_output) or $rose(nrst);
  endproperty
  a_holdValue: assert property (p_holdValue) else $error("output moved without update");

  property p_code;
    @(posedge clk_sys) disable iff (!nrst)
      fifoValid |=> analog_output == $past(fifoData[sdwp_pkg::CODE_LSB +: sdwp_pkg::CODE_BITS]);
  endproperty
  a_code: assert property (p_code) else $error("wrong code applied");

  property p_mode;
    @(posedge clk_sys) disable iff (!nrst)
      updateStrobe |-> powerMode == $past(fifoData[sdwp_pkg::MODE_LSB +: sdwp_pkg::MODE_BITS]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode not applied with code");

  property p_cntBound;
    @(posedge clk_sys) disable iff (!nrst) bitCnt <= sdwp_pkg::BIT_COUNT;
  endproperty
  a_cntBound: assert property (p_cntBound) else $error("bit counter overran");

  // an abort must never leak a partial word towards the converter
  sequence s_abortSeen;
    (state == sdwp_pkg::SDWP_SHIFT) && frameEnd;
  endsequence

  property p_abortQuiet;
    @(posedge clk_sys) disable iff (!nrst)
      s_abortSeen |=> !wordValid [*3];
  endproperty
  a_abortQuiet: assert property (p_abortQuiet) else $error("word passed after abort");

  // edges after the sixteenth are refused until frame select rises
  property p_doneHold;
    @(posedge clk_sys) disable iff (!nrst)
      (state == sdwp_pkg::SDWP_DONE) |=> $stable(shiftReg);
  endproperty
  a_doneHold: assert property (p_doneHold) else $error("shift after last bit");

  property p_strobeOne;
    @(posedge clk_sys) disable iff (!nrst)
      updateStrobe |=> !updateStrobe;
  endproperty
  a_strobeOne: assert property (p_strobeOne) else $error("update strobe too long");

  // the shifter cannot stall, so a refused word would be lost silently
  property p_room;
    @(posedge clk_sys) disable iff (!nrst)
      wordValid |-> wordReady;
  endproperty
  a_room: assert property (p_room) else $error("word refused by buffer");
endmodule

////////////////////////////////////////////////////////////////////////////
// word buffer between shifter and converter; storage is plain flip-flops
module sdwp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      fill;
  logic             doWr;
  logic             doRd;

  assign inReady  = (fill != (AW+1)'(DEPTH));
  assign outValid = (fill != '0);
  assign outData  = mem[rdPtr];
  assign doWr     = inValid && inReady;
  assign doRd     = outValid && outReady;

  always_ff @(posedge clk_sys) begin
    if (doWr) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      fill  <= '0;
    end else begin
      if (doWr) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (doRd) begin
        rdPtr <= rdPtr + 1'b1;
      end
      fill <= fill + (AW+1)'(doWr) - (AW+1)'(doRd);
    end
  end

  property p_fillBound;
    @(posedge clk_sys) disable iff (!nrst) fill <= (AW+1)'(DEPTH);
  endproperty
  a_fillBound: assert property (p_fillBound) else $error("buffer fill overran");
endmodule

// ### sdwp_master.sv
`timescale 1ns/1ns
module sdwp_master (
  input  wire logic clk_sys,
  output logic      frameSelN,
  output logic      serialClk,
  output logic      serialData
);
  // serial clock parks high between frames and never runs free
  initial begin
    frameSelN  = 1'b1;
    serialClk  = 1'b1;
    serialData = 1'b0;
  end
  // four system cycles a half period: 200 ns, far below the ceiling
  task automatic hold4();
    repeat (4) @(negedge clk_sys);
  endtask
  // sel low keeps the frame deselected, so only stray edges are sent
  task automatic send(input logic [15:0] word, input int nbits, input logic sel);
    frameSelN = ~sel;
    hold4();
    for (int i = 0; i < nbits; i++) begin
      serialData = word[15-(i%16)];
      hold4();
      serialClk = 1'b0;
      hold4();
      serialClk = 1'b1;
    end
    frameSelN  = 1'b1;
    serialData = ~serialData;
    hold4();
  endtask
endmodule

// ### sdwp_serial_dac_write_port_bench.sv
`timescale 1ns/1ns
module sdwp_serial_dac_write_port_bench;
  logic        clk_sys = 1'b0;
  logic        nrst;
  logic        frameSelN, serialClk, serialData;
  logic [11:0] analog_output;
  logic [1:0]  powerMode;
  logic        updateStrobe, abortStrobe;
  int          miscompares = 0, checks_done = 0, nUpd = 0, nAbt = 0, cycles = 0;
  localparam logic [11:0] CODES [4] = '{12'hfff, 12'h000, 12'ha5c, 12'h3a1};

  always #25 clk_sys = ~clk_sys;

  sdwp_master i_sdwp_master (.clk_sys(clk_sys), .frameSelN(frameSelN),
    .serialClk(serialClk), .serialData(serialData));
  sdwp_serial_dac_write_port i_sdwp_serial_dac_write_port (.clk_sys(clk_sys), .nrst(nrst),
    .frameSelN(frameSelN), .serialClk(serialClk), .serialData(serialData),
    .analog_output(analog_output), .powerMode(powerMode),
    .updateStrobe(updateStrobe), .abortStrobe(abortStrobe));

  ////////////////////////////////////////////////////////////////////////////////
  // strobes are one cycle wide, so they are counted rather than polled
  always @(posedge clk_sys) begin
    if (updateStrobe === 1'b1) nUpd++;
    if (abortStrobe === 1'b1) nAbt++;
    cycles++;
    if (cycles > 20000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // 40 cycles covers the synchroniser and fifo latency with margin
  task automatic frame(input logic [15:0] w, input int n, input logic sel);
    nUpd = 0;
    nAbt = 0;
    i_sdwp_master.send(w, n, sel);
    repeat (40) @(negedge clk_sys);
  endtask

  task automatic outs(input logic [11:0] code, input logic [1:0] mode);
    check({4'h0, analog_output}, {4'h0, code});
    check({14'h0, powerMode}, {14'h0, mode});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    outs(12'h000, 2'h0);
    frame(16'h3fff, 8, 1'b1);
    check(16'(nAbt), 16'h1);
    check(16'(nUpd), 16'h0);
    outs(12'h000, 2'h0);
    $display("test reset done");
  endtask

  task automatic t_write();
    for (int m = 0; m < 4; m++) begin
      frame({2'b11, 2'(m), CODES[m]}, 16, 1'b1);
      check(16'(nUpd), 16'h1);
      check(16'(nAbt), 16'h0);
      outs(CODES[m], 2'(m));
    end
    $display("test write done");
  endtask

  // one edge short is the boundary case of the abort
  task automatic t_abort();
    frame(16'h1234, 15, 1'b1);
    check(16'(nAbt), 16'h1);
    check(16'(nUpd), 16'h0);
    outs(CODES[3], 2'h3);
    $display("test abort done");
  endtask

  task automatic t_stray();
    frame(16'h2777, 16, 1'b0);
    check(16'(nUpd + nAbt), 16'h0);
    outs(CODES[3], 2'h3);
    frame(16'h1abc, 20, 1'b1);
    check(16'(nUpd), 16'h1);
    outs(12'habc, 2'h1);
    $display("test stray done");
  endtask

  task automatic t_rereset();
    nrst = 1'b0;
    repeat (2) @(negedge clk_sys);
    outs(12'h000, 2'h0);
    nrst = 1'b1;
    repeat (4) @(negedge clk_sys);
    outs(12'h000, 2'h0);
    $display("test rereset done");
  endtask

  // two frames at the shortest gap pass through the buffer one word at a time
  task automatic t_burst();
    nUpd = 0;
    nAbt = 0;
    i_sdwp_master.send({4'h2, 12'h5c3}, 16, 1'b1);
    i_sdwp_master.send({4'h1, 12'h0f0}, 16, 1'b1);
    repeat (40) @(negedge clk_sys);
    check(16'(nUpd), 16'h2);
    check(16'(nAbt), 16'h0);
    outs(12'h0f0, 2'h1);
    $display("test burst done");
  endtask

  initial begin
    nrst      = 1'b0;
    repeat (12) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (4) @(negedge clk_sys);
    t_reset();
    t_write();
    t_abort();
    t_stray();
    t_rereset();
    t_burst();
    test_done();
  end
endmodule
